//--- src/emc_ctrl_regs.vh
// Register offsets, field positions and reset values for the main control register bank
`ifndef EMC_CTRL_REGS_VH
`define EMC_CTRL_REGS_VH

// Register addresses within the bank-independent control space
`define EMC_ADDR_W          5
`define EMC_OFF_CTRL_TWO    5'h1E
`define EMC_OFF_CTRL_ONE    5'h1F
// Bank 3 registers of this block
`define EMC_OFF_REVISION    5'h12
`define EMC_OFF_CLKOUT      5'h15
`define EMC_OFF_PKTCNT      5'h19
`define EMC_OFF_CLKSTAT     5'h1D

// Main control one fields
`define EMC_C1_TX_LOGIC_RESET        7
`define EMC_C1_RX_LOGIC_RESET        6
`define EMC_C1_DMABUSY      5
`define EMC_C1_CSUM         4
`define EMC_C1_TXREQ        3
`define EMC_C1_RX_ENABLE         2
`define EMC_C1_RST          8'h00

// Main control two fields
`define EMC_C2_POINTER_AUTO_INCREMENT      7
`define EMC_C2_PACKET_COUNT_DECREMENT       6
`define EMC_C2_POWER_SAVE        5
`define EMC_C2_RSVD         4
`define EMC_C2_REGULATOR_LOW_CURRENT         3
`define EMC_C2_RST          8'h80
`define EMC_C2_IMPL_MASK    8'hF8

// Clock-out control
`define EMC_CLKOUT_POR      3'h4
`define EMC_CLOCK_READY_FLAG_BIT      0
`define EMC_BANK3           2'h3

`endif

//--- src/emc_por_hold.v
// Power-on-reset-only storage for clock-out prescale and clock-ready flag
`timescale 1ns/1ps
`default_nettype none
`include "emc_ctrl_regs.vh"

module emc_por_hold (
  // Clock and power-on reset
  input  wire       core_clk,
  input  wire       nrst,
  // Host write of prescale field
  input  wire       wrEn,
  input  wire [2:0] wrData,
  // Oscillator stable indication
  input  wire       oscStable,
  // Held state
  output reg  [2:0] clockOutPrescale_r,
  output reg        clockReadyFlag_r
);

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      clockOutPrescale_r <= `EMC_CLKOUT_POR;
    end else if (wrEn) begin
      clockOutPrescale_r <= wrData;
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      clockReadyFlag_r <= 1'b0;
    end else if (oscStable) begin
      clockReadyFlag_r <= 1'b1;
    end
  end

endmodule
`default_nettype wire

//--- src/emc_main_ctrl.v
// Main control register bank of the Ethernet controller
// Summary of operation
// - While the transmit reset bit is set the transmit logic is held in reset.
// - While the receive reset bit is set the receive logic is held in reset.
// - Host sets the DMA start bit; it reads 1 while DMA runs and 0 once DMA is idle.
// - The checksum select bit picks checksum (1) or buffer copy (0) as the DMA function.
// - The transmit request bit reads 1 while transmit is attempting a packet, else 0.
// - Receive enable lets filtered packets into the receive buffer; clear means drop all.
// - The bank select field steers register accesses to bank 0 to 3 by its value.
// - Power-on reset loads binary 100 into the clock-out prescale; other resets keep it.
// - The clock-ready flag clears on power-on reset and survives other resets.
// - The silicon revision register is read-only and ignores writes.
// - With auto-increment set the buffer pointer advances after each data access.
// - Writing 1 to packet decrement lowers the packet count by one and self-clears.
// - Power save puts MAC, PHY and control logic into low-power sleep.
// - Reserved bit 4 of control two is kept 0 by the host; bits 2 to 0 read 0.
`timescale 1ns/1ps
`default_nettype none
`include "emc_ctrl_regs.vh"

module emc_main_ctrl #(
  parameter [4:0] REVISION_ID = 5'h01  // Arbitrary value
) (
  // Clock and power-on reset
  input  wire       core_clk,
  input  wire       nrst,
  // Non-power-on device reset
  input  wire       softRst,
  // Register port from the serial command decoder
  input  wire       regWr,
  input  wire       regRd,
  input  wire [4:0] regAddr,
  input  wire [7:0] regWrData,
  output reg  [7:0] regRdData_r,
  // Buffer data access strobe
  input  wire       bufAccess,
  // Status from datapath
  input  wire       txDone,
  input  wire       txAbort,
  input  wire       dmaDone,
  input  wire       rxPktStored,
  input  wire       oscStable,
  // Control to datapath
  output reg        txLogicReset_r,
  output reg        rxLogicReset_r,
  output reg        dmaStart_r,
  output reg        dmaChecksumSelect_r,
  output reg        txRequest_r,
  output reg        rxEnable_r,
  output reg  [1:0] bankSelect_r,
  output reg        ptrAdvance_r,
  output reg        powerSave_r,
  output reg        regulatorLowCurrent_r,
  output reg  [7:0] rxPacketCount_r,
  output reg  [2:0] clockOutPrescale_r,
  output reg        clockReadyFlag_r
);

  // ********************************************************
  // Address decode
  // ********************************************************
  wire isCtrlOne = (regAddr == `EMC_OFF_CTRL_ONE);
  wire isCtrlTwo = (regAddr == `EMC_OFF_CTRL_TWO);
  wire inBank3   = (bankSelect_r == `EMC_BANK3);
  wire isClkOut  = inBank3 && (regAddr == `EMC_OFF_CLKOUT);
  wire isPktCnt  = inBank3 && (regAddr == `EMC_OFF_PKTCNT);
  wire isClkStat = inBank3 && (regAddr == `EMC_OFF_CLKSTAT);
  wire isRev     = inBank3 && (regAddr == `EMC_OFF_REVISION);

  wire wrOne = regWr && isCtrlOne;
  wire wrTwo = regWr && isCtrlTwo;
  wire wrClkOut = regWr && isClkOut;

  // ********************************************************
  // Control register one
  // ********************************************************
  reg       pointer_auto_increment_r;
  reg       reservedBit_r;
  reg       packet_count_decrement_r;
  wire      txRun  = txRequest_r & ~txLogicReset_r;

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      txLogicReset_r      <= 1'b0;
      rxLogicReset_r      <= 1'b0;
      dmaChecksumSelect_r <= 1'b0;
      rxEnable_r          <= 1'b0;
      bankSelect_r        <= 2'h0;
    end else if (softRst) begin
      txLogicReset_r      <= 1'b0;
      rxLogicReset_r      <= 1'b0;
      dmaChecksumSelect_r <= 1'b0;
      rxEnable_r          <= 1'b0;
      bankSelect_r        <= 2'h0;
    end else if (wrOne) begin
      txLogicReset_r      <= regWrData[`EMC_C1_TX_LOGIC_RESET];
      rxLogicReset_r      <= regWrData[`EMC_C1_RX_LOGIC_RESET];
      dmaChecksumSelect_r <= regWrData[`EMC_C1_CSUM];
      rxEnable_r          <= regWrData[`EMC_C1_RX_ENABLE] & ~regWrData[`EMC_C1_RX_LOGIC_RESET];
      bankSelect_r        <= regWrData[1:0];
    end else if (rxLogicReset_r) begin
      rxEnable_r          <= 1'b0;
    end
  end

  // ********************************************************
  // DMA start and busy
  // ********************************************************
  localparam [1:0] DMA_IDLE = 2'b01;
  localparam [1:0] DMA_BUSY = 2'b10;

  reg  [1:0] dmaState_r;
  reg  [1:0] dmaState_nxt;
  wire       dmaKick = wrOne && regWrData[`EMC_C1_DMABUSY];
  wire       dmaBusy = (dmaState_r == DMA_BUSY);

  always @* begin
    dmaState_nxt = dmaState_r;
    case (dmaState_r)
      DMA_IDLE: begin
        if (dmaKick) begin
          dmaState_nxt = DMA_BUSY;
        end
      end
      DMA_BUSY: begin
        // A new start while busy keeps the engine busy
        if (dmaDone && !dmaKick) begin
          dmaState_nxt = DMA_IDLE;
        end
      end
      default: begin
        dmaState_nxt = DMA_IDLE;
      end
    endcase
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dmaState_r <= DMA_IDLE;
      dmaStart_r <= 1'b0;
    end else if (softRst) begin
      dmaState_r <= DMA_IDLE;
      dmaStart_r <= 1'b0;
    end else begin
      dmaState_r <= dmaState_nxt;
      // Launch pulse only when leaving idle
      dmaStart_r <= dmaKick && (dmaState_r == DMA_IDLE);
    end
  end

  // ********************************************************
  // Transmit request
  // ********************************************************
  reg  txRequest_nxt;
  wire txEnd = txRun && (txDone || txAbort);

  always @* begin
    txRequest_nxt = txRequest_r;
    if (wrOne && regWrData[`EMC_C1_TXREQ] && !regWrData[`EMC_C1_TX_LOGIC_RESET]) begin
      txRequest_nxt = 1'b1;
    end else if (txLogicReset_r || txEnd) begin
      txRequest_nxt = 1'b0;
    end else if (wrOne && !regWrData[`EMC_C1_TXREQ]) begin
      txRequest_nxt = 1'b0;
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      txRequest_r <= 1'b0;
    end else if (softRst) begin
      txRequest_r <= 1'b0;
    end else begin
      txRequest_r <= txRequest_nxt;
    end
  end

  // ********************************************************
  // Control register two
  // ********************************************************
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pointer_auto_increment_r             <= 1'b1;
      powerSave_r           <= 1'b0;
      reservedBit_r         <= 1'b0;
      regulatorLowCurrent_r <= 1'b0;
    end else if (softRst) begin
      pointer_auto_increment_r             <= 1'b1;
      powerSave_r           <= 1'b0;
      reservedBit_r         <= 1'b0;
      regulatorLowCurrent_r <= 1'b0;
    end else if (wrTwo) begin
      pointer_auto_increment_r             <= regWrData[`EMC_C2_POINTER_AUTO_INCREMENT];
      powerSave_r           <= regWrData[`EMC_C2_POWER_SAVE];
      reservedBit_r         <= regWrData[`EMC_C2_RSVD];
      regulatorLowCurrent_r <= regWrData[`EMC_C2_REGULATOR_LOW_CURRENT];
    end
  end

  // ********************************************************
  // Buffer pointer advance
  // ********************************************************
  // pointer advance
  wire ptrAdvance_nxt = bufAccess && pointer_auto_increment_r && !softRst;

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ptrAdvance_r <= 1'b0;
    end else begin
      ptrAdvance_r <= ptrAdvance_nxt;
    end
  end

  // ********************************************************
  // Received packet count
  // ********************************************************
  reg  [7:0] rxPacketCount_nxt;
  wire       pktIn = rxPktStored && rxEnable_r;

  // Count saturates at both ends; a packet and a decrement together cancel
  always @* begin
    rxPacketCount_nxt = rxPacketCount_r;
    case ({pktIn, packet_count_decrement_r})
      2'b10: begin
        if (rxPacketCount_r != 8'hFF) begin
          rxPacketCount_nxt = rxPacketCount_r + 8'h01;
        end
      end
      2'b01: begin
        if (rxPacketCount_r != 8'h00) begin
          rxPacketCount_nxt = rxPacketCount_r - 8'h01;
        end
      end
      default: begin
        rxPacketCount_nxt = rxPacketCount_r;
      end
    endcase
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      packet_count_decrement_r        <= 1'b0;
      rxPacketCount_r <= 8'h00;
    end else if (softRst || rxLogicReset_r) begin
      packet_count_decrement_r        <= 1'b0;
      rxPacketCount_r <= 8'h00;
    end else begin
      packet_count_decrement_r        <= wrTwo && regWrData[`EMC_C2_PACKET_COUNT_DECREMENT];
      rxPacketCount_r <= rxPacketCount_nxt;
    end
  end

  // ********************************************************
  // Power-on-only state
  // ********************************************************
  wire [2:0] prescale;
  wire       clock_ready_flag;

  emc_por_hold uPorHold (
    .core_clk           (core_clk),
    .nrst               (nrst),
    .wrEn               (wrClkOut),
    .wrData             (regWrData[2:0]),
    .oscStable          (oscStable),
    .clockOutPrescale_r (prescale),
    .clockReadyFlag_r   (clock_ready_flag)
  );

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      clockOutPrescale_r <= `EMC_CLKOUT_POR;
      clockReadyFlag_r   <= 1'b0;
    end else begin
      clockOutPrescale_r <= prescale;
      clockReadyFlag_r   <= clock_ready_flag;
    end
  end

  // ********************************************************
  // Read back
  // ********************************************************
  reg [7:0] rdMux;

  wire [5:0] rdSel = {isClkStat, isPktCnt, isClkOut, isRev, isCtrlTwo, isCtrlOne};

  always @* begin
    rdMux = 8'h00;
    case (rdSel)
      6'b000001: begin
        rdMux = {txLogicReset_r, rxLogicReset_r, dmaBusy, dmaChecksumSelect_r,
                 txRequest_r, rxEnable_r, bankSelect_r};
      end
      6'b000010: begin
        rdMux = {pointer_auto_increment_r, 1'b0, powerSave_r, reservedBit_r, regulatorLowCurrent_r, 3'h0}
                & `EMC_C2_IMPL_MASK;
      end
      6'b000100: begin
        rdMux = {3'h0, REVISION_ID};
      end
      6'b001000: begin
        rdMux = {5'h00, prescale};
      end
      6'b010000: begin
        rdMux = rxPacketCount_r;
      end
      6'b100000: begin
        rdMux = {7'h00, clock_ready_flag};
      end
      default: begin
        rdMux = 8'h00;
      end
    endcase
  end

  // ********************************************************
  // Read data register
  // ********************************************************
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      regRdData_r <= 8'h00;
    end else if (regRd) begin
      regRdData_r <= rdMux;
    end
  end

endmodule
`default_nettype wire

//--- verif/emc_main_ctrl_props.sv
// Property checker for the main control register bank
`timescale 1ns/1ps
`default_nettype none
`include "emc_ctrl_regs.vh"
module emc_main_ctrl_props (
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic       softRst,
  input wire logic       regWr,
  input wire logic [4:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       bufAccess,
  input wire logic       txDone,
  input wire logic       txAbort,
  input wire logic       rxPktStored,
  input wire logic       txLogicReset_r,
  input wire logic       rxLogicReset_r,
  input wire logic       dmaStart_r,
  input wire logic       dmaChecksumSelect_r,
  input wire logic       txRequest_r,
  input wire logic       rxEnable_r,
  input wire logic [1:0] bankSelect_r,
  input wire logic       ptrAdvance_r,
  input wire logic       powerSave_r,
  input wire logic [7:0] rxPacketCount_r,
  input wire logic [2:0] clockOutPrescale_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire w1 = regWr && !softRst && regAddr == `EMC_OFF_CTRL_ONE;
  wire w2 = regWr && !softRst && regAddr == `EMC_OFF_CTRL_TWO;
  tx_reset_a: assert property (w1 |=> txLogicReset_r == $past(regWrData[7]))
    else $error("tx reset bit not applied");
  rx_reset_a: assert property (w1 |=> rxLogicReset_r == $past(regWrData[6]))
    else $error("rx reset bit not applied");
  dma_launch_a: assert property (dmaStart_r |-> $past(w1 && regWrData[5]))
    else $error("dma start without write");
  csum_sel_a: assert property (w1 |=> dmaChecksumSelect_r == $past(regWrData[4]))
    else $error("checksum select wrong");
  rx_enable_a: assert property (w1 |=> rxEnable_r == ($past(regWrData[2]) && !$past(regWrData[6])))
    else $error("rx enable wrong");
  bank_sel_a: assert property (w1 |=> bankSelect_r == $past(regWrData[1:0]))
    else $error("bank select wrong");
  tx_clear_a: assert property ((txDone || txAbort) && !w1 |=> !txRequest_r)
    else $error("tx request not cleared");
  ptr_adv_a: assert property (ptrAdvance_r |-> $past(bufAccess))
    else $error("pointer advance without access");
  pkt_dec_a: assert property ((w2 && regWrData[6]) ##1 (!rxPktStored && !softRst &&
    !rxLogicReset_r && rxPacketCount_r != 8'h00) |=>
    rxPacketCount_r == $past(rxPacketCount_r) - 8'h01)
    else $error("packet count not decremented");
  pwr_save_a: assert property (w2 |=> powerSave_r == $past(regWrData[5]))
    else $error("power save wrong");
  por_prescale_a: assert property ($rose(nrst) |-> clockOutPrescale_r == 3'h4)
    else $error("prescale not loaded at power-on");
  soft_keep_a: assert property (!regWr ##1 (softRst && !regWr) |=>
    $stable(clockOutPrescale_r)) else $error("prescale lost on soft reset");
endmodule
bind emc_main_ctrl emc_main_ctrl_props emc_main_ctrl_props_inst (.core_clk, .nrst,
  .softRst, .regWr, .regAddr, .regWrData, .bufAccess, .txDone, .txAbort, .rxPktStored,
  .txLogicReset_r, .rxLogicReset_r, .dmaStart_r, .dmaChecksumSelect_r, .txRequest_r,
  .rxEnable_r, .bankSelect_r, .ptrAdvance_r, .powerSave_r, .rxPacketCount_r,
  .clockOutPrescale_r);
`default_nettype wire

//--- verif/emc_host_model.sv
// Host-side register access model
`timescale 1ns/1ps
`default_nettype none
`include "emc_ctrl_regs.vh"
module emc_host_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] regRdData_r,
  output var  logic       regWr,
  output var  logic       regRd,
  output var  logic [4:0] regAddr,
  output var  logic [7:0] regWrData
);
  initial {regWr, regRd, regAddr, regWrData} = '0;
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk) #1;
    regAddr = a;
    regWrData = (a == `EMC_OFF_CTRL_TWO) ? d & 8'hEF : d;
    regWr = 1'b1;
    @(posedge core_clk) #1;
    regWr = 1'b0;
    regWrData = ~d;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge core_clk) #1;
    regAddr = a;
    regRd = 1'b1;
    @(posedge core_clk) #1;
    regRd = 1'b0;
    regAddr = ~a;
    d = regRdData_r;
  endtask
endmodule
`default_nettype wire

//--- verif/emc_main_ctrl_tb.sv
// Self-checking bench for the main control register bank
`timescale 1ns/1ps
`default_nettype none
`include "emc_ctrl_regs.vh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module emc_main_ctrl_tb;
  localparam [4:0] C1 = `EMC_OFF_CTRL_ONE;
  localparam [4:0] C2 = `EMC_OFF_CTRL_TWO;
  localparam [4:0] REV_ID = 5'h0A;  // Arbitrary value
  logic       core_clk = 1'b0;
  logic       nrst = 1'b0;
  logic       softRst, bufAccess, txDone, txAbort, dmaDone, rxPktStored, oscStable;
  logic       regWr, regRd, txLogicReset_r, ptrAdvance_r, powerSave_r, clockReadyFlag_r;
  logic       regulatorLowCurrent_r;
  logic [4:0] regAddr;
  logic [7:0] regWrData, regRdData_r, d, q;
  int         err_count = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  integer     seed = 32'h802A;
  emc_host_model emc_host_model_inst (.core_clk, .regRdData_r, .regWr, .regRd, .regAddr,
    .regWrData);
  emc_main_ctrl #(.REVISION_ID(REV_ID)) emc_main_ctrl_inst (.core_clk, .nrst, .softRst,
    .regWr, .regRd, .regAddr, .regWrData, .regRdData_r, .bufAccess, .txDone, .txAbort,
    .dmaDone, .rxPktStored, .oscStable, .txLogicReset_r, .rxLogicReset_r(), .dmaStart_r(),
    .dmaChecksumSelect_r(), .txRequest_r(), .rxEnable_r(), .bankSelect_r(), .ptrAdvance_r,
    .powerSave_r, .regulatorLowCurrent_r, .rxPacketCount_r(), .clockOutPrescale_r(),
    .clockReadyFlag_r);
  initial forever #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      report_and_stop();
    end
  end
  task report_and_stop;
    if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    @(posedge core_clk) #1 s = 1'b1;
    @(posedge core_clk) #1 s = 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    emc_host_model_inst.wr(a, v);
  endtask
  task automatic rchk(input string n, input logic [4:0] a, input logic [7:0] e);
    emc_host_model_inst.rd(a, q);
    `CHK(n, e, q)
  endtask
  // Receive enable reads back clear while the receive reset is held
  function automatic logic [7:0] oneExp(input logic [7:0] v);
    oneExp = {v[7:3], v[2] & ~v[6], v[1:0]};
  endfunction
  // Busy and request bits drop once dma and transmit report done
  function automatic logic [7:0] idleVal(input logic [7:0] v);
    idleVal = oneExp(v) & 8'hD7;
  endfunction
  initial begin
    {softRst, bufAccess, txDone, txAbort, dmaDone, rxPktStored, oscStable} = '0;
    repeat (16) @(posedge core_clk);
    `CHK("ready at power-on", 1'b0, clockReadyFlag_r)
    #1 nrst = 1'b1;
    oscStable = 1'b1;
    rchk("ctrl one", C1, 8'h00);
    rchk("ctrl two", C2, 8'h80);
    rchk("unmapped", 5'h00, 8'h00);
    wr(C1, 8'h03);
    rchk("prescale", `EMC_OFF_CLKOUT, 8'h04);
    wr(`EMC_OFF_REVISION, 8'hFF);
    rchk("revision", `EMC_OFF_REVISION, {3'h0, REV_ID});
    wr(`EMC_OFF_CLKOUT, 8'h02);
    pulse(softRst);
    wr(C1, 8'h07);
    rchk("prescale kept", `EMC_OFF_CLKOUT, 8'h02);
    rchk("ready kept", `EMC_OFF_CLKSTAT, 8'h01);
    repeat (3) pulse(rxPktStored);
    wr(C2, 8'hC0);
    rchk("packet count", `EMC_OFF_PKTCNT, 8'h02);
    rchk("decrement bit", C2, 8'h80);
    pulse(bufAccess);
    `CHK("advance on", 1'b1, ptrAdvance_r)
    wr(C2, 8'h28);
    `CHK("power save", 1'b1, powerSave_r)
    `CHK("regulator low", 1'b1, regulatorLowCurrent_r)
    pulse(bufAccess);
    `CHK("advance off", 1'b0, ptrAdvance_r)
    rchk("ctrl two low", C2, 8'h28);
    wr(C1, 8'h20);
    rchk("dma busy", C1, 8'h20);
    pulse(dmaDone);
    rchk("dma idle", C1, 8'h00);
    wr(C1, 8'h08);
    rchk("tx request", C1, 8'h08);
    pulse(txAbort);
    rchk("tx aborted", C1, 8'h00);
    repeat (24) begin
      d = 8'($random(seed));
      if (d[7]) d[3] = 1'b0;
      wr(C1, d);
      `CHK("tx reset", d[7], txLogicReset_r)
      rchk("ctrl one rand", C1, oneExp(d));
      pulse(dmaDone);
      pulse(txDone);
      rchk("ctrl one idle", C1, idleVal(d));
    end
    // Second power-on reset in mid-run
    nrst = 1'b0;
    @(posedge core_clk) #1;
    `CHK("ready cleared", 1'b0, clockReadyFlag_r)
    nrst = 1'b1;
    wr(C1, 8'h03);
    rchk("prescale reload", `EMC_OFF_CLKOUT, 8'h04);
    report_and_stop();
  end
endmodule
`default_nettype wire
